/* common/lvh_pkg.sv */
/*
  Shared constants for the level histogram detectors: register map, field positions, reset values,
  input module modes, tap codes and the sample code conversions.
  Assumes a single core clock and a plain strobe register port.
*/
`default_nettype none
package lvh_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int ACC_W = 24;
  localparam int PAUSE_W = 10;
  localparam int LEVELS = 8;
  localparam int FS_LANES = 5;
  localparam int TAPS = 3;
  localparam logic [2:0] EXP_MAX = 3'h5;
  localparam logic [ACC_W:0] FS_STEP = 25'h0000005;
  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_FS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FS_SRC = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IQ_SRC = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IQ_PRE = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_IQ_CTRL = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_FS_TS_HI = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_FS_TS_LO = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_IQ_TS_HI = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_IQ_TS_LO = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_FS_HIST = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_IQI_HIST = 8'h60;
  localparam logic [ADDR_W-1:0] OFS_IQQ_HIST = 8'h80;
  // Field positions
  localparam int EPOCH_BIT = 24;
  localparam int RESCALE_BIT = 3;
  localparam int TAP_LSB = 4;
  localparam int PAUSE_LSB = 16;
  localparam int FS_DONE_BIT = 0;
  localparam int IQ_DONE_BIT = 1;
  // Reset value of every control register
  localparam logic [DATA_W-1:0] CTRL_RST = 32'h00000000;
  // Tap codes
  localparam logic [1:0] TAP_AFTER_IFC = 2'h0;
  localparam logic [1:0] TAP_BEFORE_FDC = 2'h1;
  localparam logic [1:0] TAP_AFTER_FDC = 2'h2;
  typedef enum logic [1:0] {MODE_IFC, MODE_R2C, MODE_DDC} lvh_mode_e;

  // Sample code {neg, mag} to two's complement: +1,3,5,7 -> 0..3, -1..-7 -> -1..-4
  function automatic logic [2:0] to_twos(input logic [2:0] code);
    return code[2] ? {1'b1, ~code[1:0]} : {1'b0, code[1:0]};
  endfunction : to_twos

  // Inverse of to_twos
  function automatic logic [2:0] from_twos(input logic [2:0] v);
    return v[2] ? {1'b1, ~v[1:0]} : {1'b0, v[1:0]};
  endfunction : from_twos
endpackage : lvh_pkg
`default_nettype wire

/* common/lvh_rq_if.sv */
/*
  Link between the detector top and one pre-accumulator / re-quantiser branch.
  Assumes both ends run on the same core clock.
*/
`default_nettype none
interface lvh_rq_if;
  logic [2:0] in_code;
  logic in_valid;
  logic [2:0] exponent;
  logic rescale;
  logic pause_load;
  logic [9:0] pause;
  logic [2:0] out_code;
  logic out_valid;
  modport ctl (output in_code, in_valid, exponent, rescale, pause_load, pause, input out_code, out_valid);
  modport rq (input in_code, in_valid, exponent, rescale, pause_load, pause, output out_code, out_valid);
endinterface : lvh_rq_if
`default_nettype wire

/* rtl/lvh_requant.sv */
/*
  One branch of the I/Q detector front: offset-compensated pre-accumulation, re-quantisation
  with saturation and back-transform to the 3-bit sample code.
  Assumes at most one input sample per core clock.
*/
`default_nettype none
module lvh_requant
  import lvh_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  lvh_rq_if.rq bus
);
  logic [2:0] n;
  logic [9:0] win_top;
  logic [12:0] preset;
  logic [12:0] mapped;
  logic [2:0] twos;
  logic [12:0] acc_sum;
  logic signed [12:0] shr_big;
  logic signed [12:0] shr_small;
  logic sat;
  logic [2:0] rq_val;
  logic [12:0] acc_r;
  logic [9:0] cnt_r;
  logic [9:0] pause_cnt_r;
  logic [2:0] out_code_r;
  logic out_valid_r;

  // Window geometry; exponent above five is clamped
  assign n = (bus.exponent > EXP_MAX) ? EXP_MAX : bus.exponent;
  assign win_top = 10'((11'h001 << {n, 1'b0}) - 11'h001);
  assign preset = (13'h0001 << {n, 1'b0}) >> 1;
  assign twos = to_twos(bus.in_code);
  assign mapped = {{10{twos[2]}}, twos};
  assign acc_sum = ((cnt_r == 10'h000) ? preset : acc_r) + mapped;
  // plain shift by twice the exponent
  assign shr_big = $signed(acc_sum) >>> {n, 1'b0};
  assign shr_small = $signed(acc_sum) >>> n;
  assign sat = shr_small[11:2] != {10{acc_sum[12]}};
  assign rq_val = bus.rescale ? shr_big[2:0]
                : (sat ? {acc_sum[12], {2{~acc_sum[12]}}} : {acc_sum[12], shr_small[1:0]});

  // Pause skips samples first, so the window edge moves by exactly that count
  always_ff @(posedge core_clk_i)
  begin
    out_valid_r <= 1'b0;
    if (srst_i)
    begin
      acc_r <= 13'h0000;
      cnt_r <= 10'h000;
      pause_cnt_r <= 10'h000;
      out_code_r <= 3'h0;
    end
    else if (bus.pause_load)
    begin
      pause_cnt_r <= bus.pause;
      cnt_r <= 10'h000;
    end
    else if (bus.in_valid)
    begin
      if (pause_cnt_r != 10'h000)
        pause_cnt_r <= pause_cnt_r - 10'h001;
      else if (n == 3'h0)
      begin
        out_code_r <= bus.in_code;
        out_valid_r <= 1'b1;
      end
      else
      begin
        acc_r <= acc_sum;
        cnt_r <= (cnt_r == win_top) ? 10'h000 : cnt_r + 10'h001;
        if (cnt_r == win_top)
        begin
          out_code_r <= from_twos(rq_val);
          out_valid_r <= 1'b1;
        end
      end
    end
  end

  assign bus.out_code = out_code_r;
  assign bus.out_valid = out_valid_r;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  property p_bypass;
    bus.in_valid && !bus.pause_load && pause_cnt_r == 10'h000 && n == 3'h0
      |=> bus.out_valid && bus.out_code == $past(bus.in_code);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass sample not passed");
  property p_pause;
    bus.pause_load ##1 (pause_cnt_r != 10'h000 && bus.in_valid && !bus.pause_load) |=> !bus.out_valid;
  endproperty
  a_pause: assert property (p_pause) else $error("output during pause");
  property p_sat;
    bus.in_valid && !bus.pause_load && pause_cnt_r == 10'h000 && n != 3'h0 && cnt_r == win_top
      && !bus.rescale && sat && acc_sum[12] |=> bus.out_code == 3'h7;
  endproperty
  a_sat: assert property (p_sat) else $error("negative saturation wrong");
endmodule : lvh_requant
`default_nettype wire

/* rtl/lvh_top.sv */
/*
  Level histogram detectors: five-stream detector and I/Q detector with register port.
  Assumes all sample inputs, epoch and time come from logic on the core clock.
*/
`default_nettype none
// Overview of operation
// - Count eight levels over five lanes
// - Period ends on epoch or count
// - Five-lane counter steps by five
// - Register selects five-lane source module
// - Raise request when five-lane results ready
// - Latch time stamp with five-lane results
// - I and Q branches, source and tap
// - Pre-accumulate 4^N samples, zero bypasses
// - Pause shifts window once on write
// - Rescale select chooses shift, 3-bit output
// - Sixteen accumulators, period per output sample
// - After-converter tap only in that mode
// - I/Q request, pending flag readable
// - Latch time stamp with I/Q results
// - Map samples to 13-bit two's complement
// - Preset bit 2N-1 per window
// - Larger scaling is plain shift
// - Smaller scaling saturates low two bits
// - Back-transform with inverse mapping
module lvh_top #(
  parameter int NUM_SRC = 4,
  parameter int TS_W = 64
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [lvh_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [lvh_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [lvh_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic [NUM_SRC*lvh_pkg::FS_LANES*3-1:0] fs_lanes_i,
  input wire logic fs_valid_i,
  input wire logic [NUM_SRC*lvh_pkg::TAPS*6-1:0] iq_taps_i,
  input wire logic [NUM_SRC*lvh_pkg::TAPS-1:0] iq_valid_i,
  input wire logic [NUM_SRC*2-1:0] src_mode_i,
  input wire logic measurement_epoch_i,
  input wire logic [TS_W-1:0] timestamp_i,
  output logic fs_irq_o,
  output logic iq_irq_o
);
  import lvh_pkg::*;

  // Count how many of the five lanes carry one level
  function automatic logic [2:0] lane_hits(input logic [FS_LANES*3-1:0] lanes, input logic [2:0] lvl);
    logic [2:0] c;
    c = 3'h0;
    for (int i = 0; i < FS_LANES; i++)
      c = c + {2'h0, lanes[i*3 +: 3] == lvl};
    return c;
  endfunction : lane_hits

  logic [DATA_W-1:0] fs_ctrl_r;
  logic [DATA_W-1:0] fs_src_r;
  logic [DATA_W-1:0] iq_src_r;
  logic [DATA_W-1:0] iq_pre_r;
  logic [DATA_W-1:0] iq_ctrl_r;
  logic [1:0] done_r;
  logic fs_irq_r;
  logic iq_irq_r;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rd_mux;
  logic [ACC_W-1:0] fs_acc_r [LEVELS];
  logic [ACC_W-1:0] fs_res_r [LEVELS];
  logic [ACC_W-1:0] fs_acc_nxt [LEVELS];
  logic [ACC_W-1:0] iqi_acc_r [LEVELS];
  logic [ACC_W-1:0] iqq_acc_r [LEVELS];
  logic [ACC_W-1:0] iqi_res_r [LEVELS];
  logic [ACC_W-1:0] iqq_res_r [LEVELS];
  logic [ACC_W-1:0] iqi_acc_nxt [LEVELS];
  logic [ACC_W-1:0] iqq_acc_nxt [LEVELS];
  logic [ACC_W-1:0] fs_cnt_r;
  logic [ACC_W-1:0] iq_cnt_r;
  logic [TS_W-1:0] fs_ts_r;
  logic [TS_W-1:0] iq_ts_r;

  // Register write decode
  logic wr_fs_ctrl;
  logic wr_fs_src;
  logic wr_iq_src;
  logic wr_iq_pre;
  logic wr_iq_ctrl;
  logic wr_status;
  assign wr_fs_ctrl = reg_wr_i && reg_addr_i == OFS_FS_CTRL;
  assign wr_fs_src = reg_wr_i && reg_addr_i == OFS_FS_SRC;
  assign wr_iq_src = reg_wr_i && reg_addr_i == OFS_IQ_SRC;
  assign wr_iq_pre = reg_wr_i && reg_addr_i == OFS_IQ_PRE;
  assign wr_iq_ctrl = reg_wr_i && reg_addr_i == OFS_IQ_CTRL;
  assign wr_status = reg_wr_i && reg_addr_i == OFS_STATUS;

  // Five-stream source pick; an absent module feeds no samples
  logic [1:0] fs_src;
  logic fs_src_ok;
  logic [FS_LANES*3-1:0] fs_lanes;
  logic fs_valid;
  logic fs_epoch_mode;
  logic [ACC_W:0] fs_cnt_sum;
  logic fs_close;
  assign fs_src = fs_src_r[1:0];
  assign fs_src_ok = 32'(fs_src) < NUM_SRC;
  assign fs_lanes = fs_src_ok ? fs_lanes_i[32'(fs_src)*FS_LANES*3 +: FS_LANES*3] : '0;
  assign fs_valid = fs_valid_i && fs_src_ok;
  assign fs_epoch_mode = fs_ctrl_r[EPOCH_BIT];
  assign fs_cnt_sum = {1'b0, fs_cnt_r} + FS_STEP;
  assign fs_close = fs_epoch_mode ? measurement_epoch_i
                  : (fs_valid && fs_cnt_sum > {1'b0, fs_ctrl_r[ACC_W-1:0]});

  always_comb
  begin
    for (int k = 0; k < LEVELS; k++)
      fs_acc_nxt[k] = fs_acc_r[k] + (fs_valid ? {21'h000000, lane_hits(fs_lanes, 3'(k))} : 24'h000000);
  end

  // I/Q source and tap pick
  logic [1:0] iq_src;
  logic [1:0] iq_tap;
  logic iq_tap_ok;
  logic [31:0] iq_idx;
  logic [5:0] iq_word;
  logic iq_in_valid;
  logic iq_epoch_mode;
  logic iq_out_v;
  logic [ACC_W:0] iq_cnt_sum;
  logic iq_close;
  assign iq_src = iq_src_r[1:0];
  assign iq_tap = iq_src_r[TAP_LSB +: 2];
  assign iq_tap_ok = 32'(iq_src) < NUM_SRC && iq_tap <= TAP_AFTER_FDC
                   && (iq_tap != TAP_AFTER_IFC || src_mode_i[32'(iq_src)*2 +: 2] == MODE_IFC);
  assign iq_idx = iq_tap_ok ? 32'(iq_src) * TAPS + 32'(iq_tap) : 32'h00000000;
  assign iq_word = iq_taps_i[iq_idx*6 +: 6];
  assign iq_in_valid = iq_tap_ok && iq_valid_i[iq_idx];
  assign iq_epoch_mode = iq_ctrl_r[EPOCH_BIT];

  // Two identical branches share controls, so their outputs stay in step
  lvh_rq_if rq_i ();
  lvh_rq_if rq_q ();
  assign rq_i.in_code = iq_word[5:3];
  assign rq_q.in_code = iq_word[2:0];
  assign rq_i.in_valid = iq_in_valid;
  assign rq_q.in_valid = iq_in_valid;
  assign rq_i.exponent = iq_pre_r[2:0];
  assign rq_q.exponent = iq_pre_r[2:0];
  assign rq_i.rescale = iq_pre_r[RESCALE_BIT];
  assign rq_q.rescale = iq_pre_r[RESCALE_BIT];
  // write to pre-accumulator control reloads pause
  assign rq_i.pause_load = wr_iq_pre;
  assign rq_q.pause_load = wr_iq_pre;
  assign rq_i.pause = reg_wdata_i[PAUSE_LSB +: PAUSE_W];
  assign rq_q.pause = reg_wdata_i[PAUSE_LSB +: PAUSE_W];
  // Pause taken from the write data, so the new value loads at the write edge itself
  lvh_requant u_rq_i (.core_clk_i(core_clk_i), .srst_i(srst_i), .bus(rq_i.rq));
  lvh_requant u_rq_q (.core_clk_i(core_clk_i), .srst_i(srst_i), .bus(rq_q.rq));

  assign iq_out_v = rq_i.out_valid;
  assign iq_cnt_sum = {1'b0, iq_cnt_r} + 25'h0000001;
  assign iq_close = iq_epoch_mode ? measurement_epoch_i
                  : (iq_out_v && iq_cnt_sum >= {1'b0, iq_ctrl_r[ACC_W-1:0]});

  always_comb
  begin
    for (int k = 0; k < LEVELS; k++)
    begin
      iqi_acc_nxt[k] = iqi_acc_r[k] + {23'h000000, iq_out_v && rq_i.out_code == 3'(k)};
      iqq_acc_nxt[k] = iqq_acc_r[k] + {23'h000000, iq_out_v && rq_q.out_code == 3'(k)};
    end
  end

  // Control registers
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      fs_ctrl_r <= CTRL_RST;
      fs_src_r <= CTRL_RST;
      iq_src_r <= CTRL_RST;
      iq_pre_r <= CTRL_RST;
      iq_ctrl_r <= CTRL_RST;
    end
    else
    begin
      if (wr_fs_ctrl)
        fs_ctrl_r <= reg_wdata_i;
      if (wr_fs_src)
        fs_src_r <= reg_wdata_i;
      if (wr_iq_src)
        iq_src_r <= reg_wdata_i;
      if (wr_iq_pre)
        iq_pre_r <= reg_wdata_i;
      if (wr_iq_ctrl)
        iq_ctrl_r <= reg_wdata_i;
    end
  end

  // Five-stream accumulation and latch
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      fs_cnt_r <= '0;
      fs_ts_r <= '0;
      for (int k = 0; k < LEVELS; k++)
      begin
        fs_acc_r[k] <= '0;
        fs_res_r[k] <= '0;
      end
    end
    else
    begin
      fs_cnt_r <= fs_close ? '0 : (fs_valid ? fs_cnt_sum[ACC_W-1:0] : fs_cnt_r);
      for (int k = 0; k < LEVELS; k++)
      begin
        fs_acc_r[k] <= fs_close ? '0 : fs_acc_nxt[k];
        if (fs_close)
          fs_res_r[k] <= fs_acc_nxt[k];
      end
      if (fs_close)
        fs_ts_r <= timestamp_i;
    end
  end

  // I/Q accumulation and latch
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      iq_cnt_r <= '0;
      iq_ts_r <= '0;
      for (int k = 0; k < LEVELS; k++)
      begin
        iqi_acc_r[k] <= '0;
        iqq_acc_r[k] <= '0;
        iqi_res_r[k] <= '0;
        iqq_res_r[k] <= '0;
      end
    end
    else
    begin
      iq_cnt_r <= iq_close ? '0 : (iq_out_v ? iq_cnt_sum[ACC_W-1:0] : iq_cnt_r);
      for (int k = 0; k < LEVELS; k++)
      begin
        iqi_acc_r[k] <= iq_close ? '0 : iqi_acc_nxt[k];
        iqq_acc_r[k] <= iq_close ? '0 : iqq_acc_nxt[k];
        if (iq_close)
        begin
          iqi_res_r[k] <= iqi_acc_nxt[k];
          iqq_res_r[k] <= iqq_acc_nxt[k];
        end
      end
      if (iq_close)
        iq_ts_r <= timestamp_i;
    end
  end

  // Done flags: a latch in the clearing cycle wins, so no result goes unseen
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      done_r <= 2'h0;
      fs_irq_r <= 1'b0;
      iq_irq_r <= 1'b0;
    end
    else
    begin
      fs_irq_r <= fs_close;
      iq_irq_r <= iq_close;
      done_r[FS_DONE_BIT] <= fs_close || (done_r[FS_DONE_BIT] && !(wr_status && reg_wdata_i[FS_DONE_BIT]));
      done_r[IQ_DONE_BIT] <= iq_close || (done_r[IQ_DONE_BIT] && !(wr_status && reg_wdata_i[IQ_DONE_BIT]));
    end
  end
  assign fs_irq_o = fs_irq_r;
  assign iq_irq_o = iq_irq_r;

  // Read selection; histograms sit in three aligned 8-word banks
  logic rd_aligned;
  logic [2:0] rd_lvl;
  logic [2:0] rd_bank;
  assign rd_aligned = reg_addr_i[1:0] == 2'h0;
  assign rd_lvl = reg_addr_i[4:2];
  assign rd_bank = reg_addr_i[7:5];
  always_comb
  begin
    rd_mux = '0;
    if (rd_aligned)
    begin
      if (rd_bank == OFS_FS_HIST[7:5])
        rd_mux = {8'h00, fs_res_r[rd_lvl]};
      else if (rd_bank == OFS_IQI_HIST[7:5])
        rd_mux = {8'h00, iqi_res_r[rd_lvl]};
      else if (rd_bank == OFS_IQQ_HIST[7:5])
        rd_mux = {8'h00, iqq_res_r[rd_lvl]};
      else
        case (reg_addr_i)
          OFS_FS_CTRL: rd_mux = fs_ctrl_r;
          OFS_FS_SRC: rd_mux = fs_src_r;
          OFS_IQ_SRC: rd_mux = iq_src_r;
          OFS_IQ_PRE: rd_mux = iq_pre_r;
          OFS_IQ_CTRL: rd_mux = iq_ctrl_r;
          OFS_STATUS: rd_mux = {30'h00000000, done_r};
          OFS_FS_TS_HI: rd_mux = fs_ts_r[TS_W-1 -: DATA_W];
          OFS_FS_TS_LO: rd_mux = fs_ts_r[DATA_W-1:0];
          OFS_IQ_TS_HI: rd_mux = iq_ts_r[TS_W-1 -: DATA_W];
          OFS_IQ_TS_LO: rd_mux = iq_ts_r[DATA_W-1:0];
          default: rd_mux = '0;
        endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      rdata_r <= '0;
    else
      rdata_r <= reg_rd_i ? rd_mux : '0;
  end
  assign reg_rdata_o = rdata_r;

  // Helper sum of all five-stream accumulators
  logic [ACC_W+2:0] fs_tot;
  always_comb
  begin
    fs_tot = '0;
    for (int k = 0; k < LEVELS; k++)
      fs_tot = fs_tot + {3'h0, fs_acc_r[k]};
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  property p_fs_count;
    fs_valid && !fs_close |=> fs_tot == $past(fs_tot) + 27'h0000005;
  endproperty
  a_fs_count: assert property (p_fs_count) else $error("five lanes not all counted");
  property p_fs_close;
    !fs_epoch_mode && fs_valid && fs_cnt_sum > {1'b0, fs_ctrl_r[ACC_W-1:0]} |=> fs_cnt_r == '0 && fs_tot == '0;
  endproperty
  a_fs_close: assert property (p_fs_close) else $error("period not closed at length");
  property p_fs_step;
    fs_valid && !fs_close |=> fs_cnt_r == $past(fs_cnt_r) + 24'h000005;
  endproperty
  a_fs_step: assert property (p_fs_step) else $error("counter step not five");
  property p_fs_irq;
    fs_close |=> fs_irq_o && done_r[FS_DONE_BIT] ##1 !fs_irq_o || $past(fs_close);
  endproperty
  a_fs_irq: assert property (p_fs_irq) else $error("five-lane request wrong");
  property p_fs_ts;
    fs_close |=> fs_ts_r == $past(timestamp_i);
  endproperty
  a_fs_ts: assert property (p_fs_ts) else $error("five-lane stamp wrong");
  property p_iq_step;
    !iq_epoch_mode && iq_out_v && !iq_close |=> iq_cnt_r == $past(iq_cnt_r) + 24'h000001;
  endproperty
  a_iq_step: assert property (p_iq_step) else $error("I/Q period count wrong");
  property p_iq_tap;
    iq_tap == TAP_AFTER_IFC && src_mode_i[32'(iq_src)*2 +: 2] != MODE_IFC |-> !iq_in_valid;
  endproperty
  a_iq_tap: assert property (p_iq_tap) else $error("invalid tap counted");
  sequence s_iq_done_poll;
    (done_r[IQ_DONE_BIT] && !iq_irq_o) ##0 (reg_rd_i && reg_addr_i == OFS_STATUS);
  endsequence
  property p_iq_pend;
    s_iq_done_poll |=> reg_rdata_o[IQ_DONE_BIT];
  endproperty
  a_iq_pend: assert property (p_iq_pend) else $error("I/Q pending not readable");
  property p_iq_ts;
    iq_close |=> iq_ts_r == $past(timestamp_i);
  endproperty
  a_iq_ts: assert property (p_iq_ts) else $error("I/Q stamp wrong");
endmodule : lvh_top
`default_nettype wire

/* testbench/lvh_src_model.sv */
/* Input module model: five-lane and I/Q sample sources for lvh_top.
   Assumes one core clock; each module's mode is fixed. */
`default_nettype none
module lvh_src_model (
  input wire logic core_clk_i,
  output logic [59:0] fs_lanes_o,
  output logic fs_valid_o,
  output logic [71:0] iq_taps_o,
  output logic [11:0] iq_valid_o,
  output logic [7:0] src_mode_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import lvh_pkg::*;
  logic fs_go = 1'b0;
  logic iq_go = 1'b0;
  logic [14:0] fs_val = '0;
  logic [5:0] iq_val = '0;
  logic [71:0] noise = 72'hA5A5A5A5A5A5A5A5A5;
  int fs_m = 0;
  int iq_w = 0;
  // Idle lines flip every cycle, so stale data never passes for a sample
  always @(posedge core_clk_i) noise <= ~noise;
  // Modules: 0 INPUT_FORMAT_CONVERTER, 1 R2C, 2 DDC, 3 INPUT_FORMAT_CONVERTER
  assign src_mode_o = {MODE_IFC, MODE_DDC, MODE_R2C, MODE_IFC};
  assign fs_valid_o = fs_go;
  assign iq_valid_o = {12{iq_go}};
  // Unselected words stay valid with noise to expose a wrong source pick
  for (genvar g = 0; g < 12; g++)
  begin : g_word
    assign iq_taps_o[g*6 +: 6] = (iq_go && iq_w == g) ? iq_val : noise[g*6 +: 6];
    if (g < 4)
    begin : g_mod
      assign fs_lanes_o[g*15 +: 15] = (fs_go && fs_m == g) ? fs_val : noise[g*15 +: 15];
    end
  end
  // One call is one cycle of samples; calls run back to back
  task automatic fs_send(input logic [14:0] v, input int m);
    @(posedge core_clk_i);
    fs_val <= v;
    fs_m <= m;
    fs_go <= 1'b1;
  endtask : fs_send
  task automatic iq_send(input logic [5:0] v, input int w);
    @(posedge core_clk_i);
    iq_val <= v;
    iq_w <= w;
    iq_go <= 1'b1;
  endtask : iq_send
  task automatic idle;
    @(posedge core_clk_i);
    fs_go <= 1'b0;
    iq_go <= 1'b0;
  endtask : idle
endmodule : lvh_src_model
`default_nettype wire

/* testbench/lvh_top_test.sv */
/* Self-checking bench for lvh_top: each read notes its expected answer in a queue.
   Assumes default parameters and the model of the input modules. */
`default_nettype none
module lvh_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import lvh_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_q = 1'b0;
  logic epoch = 1'b0;
  logic [63:0] ts = '0;
  logic [DATA_W-1:0] exp_q[$];
  string name_q[$];
  int error_cnt = 0;
  int n_tests = 0;
  int seed = 17321;
  wire [DATA_W-1:0] rdata;
  wire [59:0] fs_lanes;
  wire [71:0] iq_taps;
  wire [11:0] iq_valid;
  wire [7:0] src_mode;
  wire fs_valid;
  wire fs_irq;
  wire iq_irq;
  // 10 MHz core clock
  always #50 core_clk = ~core_clk;
  lvh_top u_lvh_top (.core_clk_i(core_clk), .srst_i(srst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .fs_lanes_i(fs_lanes), .fs_valid_i(fs_valid),
    .iq_taps_i(iq_taps), .iq_valid_i(iq_valid), .src_mode_i(src_mode), .measurement_epoch_i(epoch),
    .timestamp_i(ts), .fs_irq_o(fs_irq), .iq_irq_o(iq_irq));
  lvh_src_model u_lvh_src_model (.core_clk_i(core_clk), .fs_lanes_o(fs_lanes), .fs_valid_o(fs_valid),
    .iq_taps_o(iq_taps), .iq_valid_o(iq_valid), .src_mode_o(src_mode));
  task automatic check(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] expv);
    n_tests++;
    if (seen !== expv)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, expv, seen);
    end
  endtask : check
  // Read data stand only in the cycle after the strobe
  always @(posedge core_clk)
  begin
    rd_q <= rd;
    if (rd_q)
      check(name_q.pop_front(), rdata, exp_q.pop_front());
  end
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input string what, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    name_q.push_back(what);
    @(posedge core_clk);
    rd <= 1'b0;
  endtask : rd_reg
  // Bounded wait for the one-cycle request pulse
  task automatic wait_irq(input logic iq);
    int n;
    n = 0;
    while (n < 40 && (iq ? iq_irq : fs_irq) !== 1'b1)
    begin
      @(posedge core_clk);
      n++;
    end
    check("irq", 32'(n < 40), 32'h1);
  endtask : wait_irq
  // Steps of five lanes from module 1; the period ends on epoch if ep, else on the first step that takes the count past the length
  task automatic fs_case(input logic [23:0] len, input logic ep);
    logic [14:0] lanes;
    int cnt[8];
    int steps;
    foreach (cnt[k]) cnt[k] = 0;
    steps = ep ? 3 : int'(len) / 5 + 1;
    ts <= {$random(seed), $random(seed)};
    wr_reg(OFS_FS_SRC, 32'h1);
    wr_reg(OFS_FS_CTRL, {7'h00, ep, len});
    for (int s = 0; s < steps; s++)
    begin
      lanes = 15'($random(seed));
      for (int l = 0; l < FS_LANES; l++) cnt[lanes[l*3 +: 3]]++;
      u_lvh_src_model.fs_send(lanes, 1);
    end
    epoch <= ep;
    u_lvh_src_model.idle();
    epoch <= 1'b0;
    wait_irq(1'b0);
    for (int k = 0; k < 8; k++) rd_reg("fs_hist", OFS_FS_HIST + 8'(4 * k), 32'(cnt[k]));
    rd_reg("fs_ts_hi", OFS_FS_TS_HI, ts[63:32]);
    rd_reg("fs_ts_lo", OFS_FS_TS_LO, ts[31:0]);
    rd_reg("status", OFS_STATUS, 32'h1);
    wr_reg(OFS_STATUS, 32'h1);
    $display("five-stream case done, length %0d epoch %0d", len, ep);
  endtask : fs_case
  // Constant samples from module 1 after the final converter, after p paused samples
  task automatic iq_case(input logic [2:0] n, input logic rs, input int p, input logic [5:0] smp,
    input logic [23:0] len, input logic [2:0] ei, input logic [2:0] eq);
    ts <= {$random(seed), $random(seed)};
    wr_reg(OFS_IQ_SRC, 32'h1 | (32'(TAP_AFTER_FDC) << TAP_LSB));
    wr_reg(OFS_IQ_CTRL, {8'h00, len});
    wr_reg(OFS_IQ_PRE, (32'(p) << PAUSE_LSB) | (32'(rs) << RESCALE_BIT) | 32'(n));
    for (int s = 0; s < p; s++) u_lvh_src_model.iq_send(6'h00, TAPS + 2);
    for (int s = 0; s < (int'(len) << (2 * n)); s++) u_lvh_src_model.iq_send(smp, TAPS + 2);
    u_lvh_src_model.idle();
    wait_irq(1'b1);
    for (int k = 0; k < 8; k++)
    begin
      rd_reg("iq_i_hist", OFS_IQI_HIST + 8'(4 * k), k == ei ? {8'h00, len} : 32'h0);
      rd_reg("iq_q_hist", OFS_IQQ_HIST + 8'(4 * k), k == eq ? {8'h00, len} : 32'h0);
    end
    rd_reg("iq_ts_hi", OFS_IQ_TS_HI, ts[63:32]);
    rd_reg("iq_ts_lo", OFS_IQ_TS_LO, ts[31:0]);
    rd_reg("status", OFS_STATUS, 32'h2);
    wr_reg(OFS_STATUS, 32'h2);
    $display("I/Q case done, exponent %0d rescale %0d", n, rs);
  endtask : iq_case
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run
  // Main sequence
  initial
  begin
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    rd_reg("fs_ctrl", OFS_FS_CTRL, CTRL_RST);
    rd_reg("iq_pre", OFS_IQ_PRE, CTRL_RST);
    rd_reg("status", OFS_STATUS, 32'h0);
    wr_reg(OFS_FS_HIST, 32'hFFFFFFFF);
    rd_reg("ro_hist", OFS_FS_HIST, 32'h0);
    rd_reg("unmapped", 8'hFC, 32'h0);
    fs_case(24'h000004, 1'b0);
    fs_case(24'h000005, 1'b0);
    fs_case(24'h000009, 1'b0);
    fs_case(24'h000001, 1'b1);
    iq_case(3'h0, 1'b0, 0, 6'h2A, 24'h000003, 3'h5, 3'h2);
    iq_case(3'h1, 1'b1, 3, 6'h1F, 24'h000002, 3'h3, 3'h7);
    iq_case(3'h2, 1'b0, 0, 6'h38, 24'h000001, 3'h7, 3'h2);
    // converter tap on a real-to-complex module counts nothing
    wr_reg(OFS_IQ_SRC, 32'h1 | (32'(TAP_AFTER_IFC) << TAP_LSB));
    wr_reg(OFS_IQ_PRE, 32'h0);
    wr_reg(OFS_IQ_CTRL, 32'h1 << EPOCH_BIT);
    repeat (4) u_lvh_src_model.iq_send(6'h2A, TAPS);
    epoch <= 1'b1;
    u_lvh_src_model.idle();
    epoch <= 1'b0;
    wait_irq(1'b1);
    rd_reg("iq_bad_tap", OFS_IQI_HIST + 8'h14, 32'h0);
    wr_reg(OFS_STATUS, 32'h3);
    $display("tap rejection case done");
    rd_reg("status", OFS_STATUS, 32'h0);
    repeat (3) @(posedge core_clk);
    complete_run();
  end
  // Watchdog: the sequence needs well under 5000 cycles
  initial
  begin
    #500000;
    error_cnt++;
    complete_run();
  end
endmodule : lvh_top_test
`default_nettype wire
